/* hw/ahc_config_regs.sv */
// Register bank and drive mapping for the audio-to-vibration path.
// Assumes the bus interface hands over decoded single-cycle requests.
`timescale 1ns/1ns
`default_nettype none
module ahc_config_regs
  import ahc_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire ahc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [7:0] analog_input_trigger_pin,
  input wire logic audio_mode,
  input wire logic closed_loop_mode,
  input wire logic [7:0] overdrive_level,
  output logic [7:0] drive_level,
  output logic drive_update,
  output logic [7:0] full_scale_ref,
  output logic [7:0] rated_level_out
);
  localparam int TW = $clog2(TICK_LEN);

  if (TICK_LEN < 2) begin : g_bad_tick
    $error("TICK_LEN must be at least 2");
  end

  logic [1:0] peak_window_select;
  logic [1:0] lowpass_cutoff_select;
  logic [7:0] input_floor_level;
  logic [7:0] input_full_scale_level;
  logic [7:0] drive_floor_level;
  logic [7:0] drive_ceiling_level;
  logic [7:0] motor_rated_level;
  logic [TW-1:0] tick_cnt;
  logic tick;
  logic [7:0] filt_level;
  ahc_peak_t peak;
  logic [7:0] next_drive;
  logic [7:0] lo_drive;
  logic [7:0] in_span;
  logic [7:0] drv_span;
  logic [15:0] scaled;
  logic [7:0] next_rdata;

  // Sample tick divider.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == TW'(TICK_LEN - 1));
      tick_cnt <= (tick_cnt == TW'(TICK_LEN - 1)) ? '0 : tick_cnt + 1'b1;
    end
  end

  // Register writes; offsets outside the bank are ignored.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      peak_window_select <= PEAK_SEL_RST;
      lowpass_cutoff_select <= CUT_SEL_RST;
      input_floor_level <= MIN_INPUT_RST;
      input_full_scale_level <= MAX_INPUT_RST;
      drive_floor_level <= MIN_DRIVE_RST;
      drive_ceiling_level <= MAX_DRIVE_RST;
      motor_rated_level <= RATED_RST;
    end else if (reg_req.wr) begin
      unique case (reg_req.addr)
        ADDR_AUDIO_CTRL: begin
          peak_window_select <= reg_req.wdata[PEAK_SEL_LSB +: 2];
          lowpass_cutoff_select <= reg_req.wdata[CUT_SEL_LSB +: 2];
        end
        ADDR_MIN_INPUT: input_floor_level <= reg_req.wdata;
        ADDR_MAX_INPUT: input_full_scale_level <= reg_req.wdata;
        ADDR_MIN_DRIVE: drive_floor_level <= reg_req.wdata;
        ADDR_MAX_DRIVE: drive_ceiling_level <= reg_req.wdata;
        ADDR_RATED: motor_rated_level <= reg_req.wdata;
        default: begin
        end
      endcase
    end
  end

  // Readback; reserved control bits and unmapped offsets read as zero.
  always_comb begin
    unique case (reg_req.addr)
      ADDR_AUDIO_CTRL: next_rdata = {4'h0, peak_window_select,
                                     lowpass_cutoff_select};
      ADDR_MIN_INPUT: next_rdata = input_floor_level;
      ADDR_MAX_INPUT: next_rdata = input_full_scale_level;
      ADDR_MIN_DRIVE: next_rdata = drive_floor_level;
      ADDR_MAX_DRIVE: next_rdata = drive_ceiling_level;
      ADDR_RATED: next_rdata = motor_rated_level;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  ahc_lowpass u_lowpass (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .cut_sel(lowpass_cutoff_select),
    .level_in(analog_input_trigger_pin),
    .level_out(filt_level)
  );

  ahc_peak_detect u_peak (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .peak_sel(peak_window_select),
    .level_in(filt_level),
    .peak(peak)
  );

  // Input and drive codes share one 1.8 V / 255 and 100 % / 255 scale, so
  // the mapping works on raw codes. If the ceiling is set under the floor,
  // the ceiling wins so the actuator is never overdriven.
  always_comb begin
    lo_drive = (drive_ceiling_level < drive_floor_level) ?
               drive_ceiling_level : drive_floor_level;
    drv_span = drive_ceiling_level - lo_drive;
    in_span = input_full_scale_level - input_floor_level;
    scaled = 16'h0000;
    if (!audio_mode || peak.level < input_floor_level) begin
      next_drive = 8'h00;
    end else if (peak.level >= input_full_scale_level) begin
      next_drive = drive_ceiling_level;
    end else begin
      scaled = 16'((peak.level - input_floor_level) * drv_span) /
               {8'h00, in_span};
      next_drive = lo_drive + scaled[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drive_level <= 8'h00;
      drive_update <= 1'b0;
    end else begin
      drive_update <= peak.done;
      if (!audio_mode) begin
        drive_level <= 8'h00;
      end else if (peak.done) begin
        drive_level <= next_drive;
      end
    end
  end

  // The calibration engine reads the rated level; see host duties.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      full_scale_ref <= 8'h00;
      rated_level_out <= RATED_RST;
    end else begin
      rated_level_out <= motor_rated_level;
      full_scale_ref <= closed_loop_mode ? motor_rated_level
                                         : overdrive_level;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_peak_write: assert property (
    reg_req.wr && reg_req.addr == ADDR_AUDIO_CTRL |=>
    peak_window_select == $past(reg_req.wdata[3:2]))
    else $error("peak window field not written");
  chk_cut_readback: assert property (
    reg_req.wr && reg_req.addr == ADDR_AUDIO_CTRL ##1
    reg_req.rd && reg_req.addr == ADDR_AUDIO_CTRL |=>
    reg_rdata == {4'h0, $past(reg_req.wdata[3:0], 2)})
    else $error("control readback wrong");
  chk_floor_reject: assert property (
    peak.done && audio_mode && peak.level < input_floor_level |=>
    drive_level == 8'h00 && drive_update)
    else $error("sub-floor level drove output");
  chk_floor_write: assert property (
    reg_req.wr && reg_req.addr == ADDR_MIN_INPUT ##1 reg_req.rd &&
    reg_req.addr == ADDR_MIN_INPUT |=>
    reg_rdata == $past(reg_req.wdata, 2))
    else $error("input floor readback wrong");
  chk_full_scale: assert property (
    peak.done && audio_mode && peak.level >= input_full_scale_level &&
    peak.level >= input_floor_level |=>
    drive_level == $past(drive_ceiling_level))
    else $error("full scale did not give ceiling");
  chk_drive_floor: assert property (
    peak.done && audio_mode && peak.level >= input_floor_level |=>
    drive_level >= $past(lo_drive))
    else $error("drive under floor");
  chk_drive_ceiling: assert property (
    peak.done && audio_mode |=>
    drive_level <= $past(drive_ceiling_level))
    else $error("drive above ceiling");
  chk_closed_ref: assert property (
    closed_loop_mode |=> full_scale_ref == $past(motor_rated_level))
    else $error("closed loop ref not rated level");
  chk_open_ref: assert property (
    !closed_loop_mode |=> full_scale_ref == $past(overdrive_level))
    else $error("open loop ref not overdrive");
  chk_map_range: assert property (
    peak.done && audio_mode && peak.level >= input_floor_level &&
    peak.level < input_full_scale_level |=>
    drive_level >= $past(lo_drive) &&
    drive_level <= $past(drive_ceiling_level))
    else $error("mapped drive out of range");
  chk_unmapped_rd: assert property (
    reg_req.rd && (reg_req.addr < ADDR_AUDIO_CTRL ||
    reg_req.addr > ADDR_RATED) |=> reg_rdata == 8'h00 && reg_rvalid)
    else $error("unmapped read not zero");

  // Ticks counted since the last window end. A control write in mid-window
  // changes its length on purpose, so such a window is not measured.
  logic [5:0] win_ticks;
  logic win_clean;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      win_ticks <= 6'h00;
      win_clean <= 1'b1;
    end else if (peak.done) begin
      win_ticks <= 6'h00;
      win_clean <= 1'b1;
    end else begin
      if (tick) begin
        win_ticks <= win_ticks + 6'h01;
      end
      if (reg_req.wr && reg_req.addr == ADDR_AUDIO_CTRL) begin
        win_clean <= 1'b0;
      end
    end
  end

  chk_window_len: assert property (
    peak.done && win_clean |->
    win_ticks == PEAK_STEP_MS + PEAK_STEP_MS * {4'h0, peak_window_select})
    else $error("peak window length wrong");
  chk_rvalid_pulse: assert property (
    reg_req.rd |=> reg_rvalid)
    else $error("read not answered");
  chk_rvalid_idle: assert property (
    !reg_req.rd |=> !reg_rvalid)
    else $error("read answer without a read");
  chk_ctrl_reserved: assert property (
    reg_req.rd && reg_req.addr == ADDR_AUDIO_CTRL |=>
    reg_rdata[7:4] == 4'h0)
    else $error("reserved control bits not zero");
  chk_update_pulse: assert property (
    peak.done |=> drive_update)
    else $error("window end not flagged");
  chk_update_idle: assert property (
    !peak.done |=> !drive_update)
    else $error("update flag without window end");
  chk_mode_off: assert property (
    !audio_mode |=> drive_level == 8'h00)
    else $error("drive left on outside audio mode");
  chk_drive_hold: assert property (
    audio_mode && !peak.done |=> $stable(drive_level))
    else $error("drive moved between window ends");
  chk_rated_copy: assert property (
    1'b1 |=> rated_level_out == $past(motor_rated_level))
    else $error("rated level copy stale");
  chk_reset_vals: assert property (
    $rose(rst_n) |-> peak_window_select == PEAK_SEL_RST &&
    lowpass_cutoff_select == CUT_SEL_RST &&
    input_floor_level == MIN_INPUT_RST &&
    input_full_scale_level == MAX_INPUT_RST &&
    drive_floor_level == MIN_DRIVE_RST &&
    drive_ceiling_level == MAX_DRIVE_RST &&
    motor_rated_level == RATED_RST && !reg_rvalid &&
    drive_level == 8'h00)
    else $error("state after reset wrong");

  cov_ctrl_write: cover property (
    reg_req.wr && reg_req.addr == ADDR_AUDIO_CTRL);
  cov_drive_mid: cover property (
    peak.done && audio_mode && peak.level > input_floor_level ##1
    drive_level > 8'h00);
  cov_floor_reject: cover property (
    peak.done && audio_mode && peak.level < input_floor_level);
  cov_closed_loop: cover property ($rose(closed_loop_mode));
  cov_long_window: cover property (peak.done && peak_window_select == 2'h3);
endmodule
`default_nettype wire

/* hw/ahc_lowpass.sv */
// One-pole low-pass filter on the rectified input level.
// Assumes tick is a one-cycle pulse at the 1 kHz sample rate.
`timescale 1ns/1ns
`default_nettype none
module ahc_lowpass
  import ahc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [1:0] cut_sel,
  input wire logic [7:0] level_in,
  output logic [7:0] level_out
);
  logic [15:0] acc;
  logic signed [16:0] diff;
  logic signed [25:0] prod;
  logic signed [25:0] step;

  // Eight fraction bits keep small steps from stalling the filter.
  always_comb begin
    diff = $signed({1'b0, level_in, 8'h00}) - $signed({1'b0, acc});
    prod = diff * $signed({1'b0, LPF_COEF[cut_sel]});
    step = prod >>> 8;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc <= 16'h0000;
    end else if (tick) begin
      acc <= acc + step[15:0];
    end
  end

  assign level_out = acc[15:8];
endmodule
`default_nettype wire

/* hw/ahc_peak_detect.sv */
// Peak hold over a window of 10 to 40 sample ticks.
// Assumes tick is a one-cycle pulse every millisecond.
`timescale 1ns/1ns
`default_nettype none
module ahc_peak_detect
  import ahc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [1:0] peak_sel,
  input wire logic [7:0] level_in,
  output ahc_peak_t peak
);
  logic [5:0] ms_cnt;
  logic [5:0] window_ms;
  logic [7:0] running;
  logic [7:0] next_running;

  always_comb begin
    window_ms = 6'(PEAK_STEP_MS * ({4'h0, peak_sel} + 6'h01));
    next_running = (level_in > running) ? level_in : running;
  end

  // A shortened window takes effect at once; the count wraps at the end.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ms_cnt <= 6'h00;
      running <= 8'h00;
      peak <= '0;
    end else begin
      peak.done <= 1'b0;
      if (tick) begin
        if (ms_cnt >= window_ms - 6'h01) begin
          ms_cnt <= 6'h00;
          running <= 8'h00;
          peak.level <= next_running;
          peak.done <= 1'b1;
        end else begin
          ms_cnt <= ms_cnt + 6'h01;
          running <= next_running;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* hw/ahc_pkg.sv */
// Shared constants and carrier types for the audio-to-vibration config bank.
// Assumes a 20 MHz core clock and a host register port decoded upstream.
package ahc_pkg;

  // Register offsets.
  localparam logic [7:0] ADDR_AUDIO_CTRL = 8'h11;
  localparam logic [7:0] ADDR_MIN_INPUT = 8'h12;
  localparam logic [7:0] ADDR_MAX_INPUT = 8'h13;
  localparam logic [7:0] ADDR_MIN_DRIVE = 8'h14;
  localparam logic [7:0] ADDR_MAX_DRIVE = 8'h15;
  localparam logic [7:0] ADDR_RATED = 8'h16;

  // Field positions within audio_path_control.
  localparam int PEAK_SEL_LSB = 2;
  localparam int CUT_SEL_LSB = 0;

  // Reset values.
  localparam logic [1:0] PEAK_SEL_RST = 2'h1;
  localparam logic [1:0] CUT_SEL_RST = 2'h1;
  localparam logic [7:0] MIN_INPUT_RST = 8'h19;
  localparam logic [7:0] MAX_INPUT_RST = 8'hff;
  localparam logic [7:0] MIN_DRIVE_RST = 8'h19;
  localparam logic [7:0] MAX_DRIVE_RST = 8'hff;
  localparam logic [7:0] RATED_RST = 8'h3f;

  // Timing: the audio path runs on a 1 ms sample tick.
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  // Peak window is (code + 1) times this many ticks: 10/20/30/40 ms.
  localparam logic [5:0] PEAK_STEP_MS = 6'h0a;

  // One-pole low-pass weights for 100/125/150/200 Hz at a 1 kHz rate,
  // as 1 - exp(-2*pi*fc/fs) in units of 1/256, indexed by cutoff code.
  localparam logic [3:0][7:0] LPF_COEF = {8'hb7, 8'h9c, 8'h8b, 8'h77};

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ahc_reg_req_t;

  typedef struct packed {
    logic [7:0] level;
    logic done;
  } ahc_peak_t;

endpackage

/* verif/ahc_host_model.sv */
// Host side of the register port: single-cycle writes and reads.
// Assumes the bank takes a request at the rising edge where wr or rd is high.
`timescale 1ns/1ns
`default_nettype none
module ahc_host_model
  import ahc_pkg::*;
(
  input wire logic clk,
  output var ahc_reg_req_t req
);
  initial req = '0;
  // After a request the idle bus shows inverted address and data.
  // Stale values must never pass for a live request.
  task automatic op(input logic w, input logic r, input logic [7:0] a,
                    input logic [7:0] d);
    @(posedge clk);
    #2 req = '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge clk);
    #2 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // A write and a read of the same offset on two consecutive edges.
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #2 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~d};
    @(posedge clk);
    #2 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // The rated level goes in before any calibration and after each change.
  task automatic load_rated(input logic [7:0] v);
    op(1'b1, 1'b0, ADDR_RATED, v);
  endtask
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the audio-to-vibration register bank.
// Assumes a 20 MHz clock and a shortened sample tick of four cycles.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import ahc_pkg::*;
;
  localparam int TB_TICK = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  ahc_reg_req_t req;
  logic [7:0] rdata, pin, od, drv, fsr, rated;
  logic rvalid, amode, cl, upd;
  int n_errors = 0;
  int n_tests = 0;
  int i;
  logic [7:0] v;
  logic [7:0] exp_q[$];
  always #25 clk = ~clk;
  ahc_host_model host (.clk(clk), .req(req));
  ahc_config_regs #(.TICK_LEN(TB_TICK)) dut (.clk(clk), .rst_n(rst_n),
    .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .analog_input_trigger_pin(pin), .audio_mode(amode),
    .closed_loop_mode(cl), .overdrive_level(od), .drive_level(drv),
    .drive_update(upd), .full_scale_ref(fsr), .rated_level_out(rated));
  task automatic finish_test;
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(string s, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    host.op(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    host.op(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic wr_then_rd(logic [7:0] a, logic [7:0] d, logic [7:0] e);
    exp_q.push_back(e);
    host.wr_rd(a, d);
  endtask
  // Each read answer is matched against the oldest noted expectation.
  always @(negedge clk) begin
    if (rst_n && rvalid === 1'b1) begin
      if (exp_q.size() == 0)
        check("spare rvalid", 8'h00, 8'h01);
      else
        check("reg_rdata", exp_q.pop_front(), rdata);
    end
  end
  // Windows end on drive_update; the wait is bounded by 200 cycles.
  task automatic wait_upd(input int n);
    int k;
    repeat (n) begin
      k = 0;
      @(negedge clk);
      while (upd !== 1'b1 && k < 200) begin
        @(negedge clk);
        k++;
      end
      if (k == 200) begin
        check("drive_update", 8'h01, 8'h00);
        finish_test();
      end
    end
  endtask
  function automatic logic [7:0] map_lvl(int p);
    int r;
    r = 'h19 + (p - 'h19) * ('hc0 - 'h19) / ('h80 - 'h19);
    return r[7:0];
  endfunction
  task automatic set_in(logic [7:0] p);
    @(posedge clk);
    #2 pin = p;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    check("run length", 8'h00, 8'h01);
    finish_test();
  end
  initial begin
    void'($urandom(32'hd4f87b10));
    pin = 8'h00;
    amode = 1'b0;
    cl = 1'b0;
    od = 8'($urandom);
    repeat (12) @(posedge clk);
    #2 rst_n = 1'b1;
    rd(ADDR_AUDIO_CTRL, 8'h05);
    rd(ADDR_MIN_INPUT, 8'h19);
    rd(ADDR_MAX_INPUT, 8'hff);
    rd(ADDR_MIN_DRIVE, 8'h19);
    rd(ADDR_MAX_DRIVE, 8'hff);
    rd(ADDR_RATED, 8'h3f);
    check("rated_level_out", 8'h3f, rated);
    check("full_scale_ref", od, fsr);
    for (i = 0; i < 16; i++) begin
      v = 8'($urandom);
      v[3:0] = i[3:0];
      wr_then_rd(ADDR_AUDIO_CTRL, v, {4'h0, v[3:0]});
    end
    for (i = 'h12; i <= 'h16; i++) begin
      v = 8'($urandom);
      wr_then_rd(i[7:0], v, v);
    end
    wr(8'h17, 8'h5a);
    rd(8'h17, 8'h00);
    rd(8'h10, 8'h00);
    @(posedge clk);
    #2 cl = 1'b1;
    v = 8'($urandom);
    host.load_rated(v);
    repeat (2) @(negedge clk);
    check("full_scale_ref", v, fsr);
    check("rated_level_out", v, rated);
    @(posedge clk);
    #2 cl = 1'b0;
    repeat (2) @(negedge clk);
    check("full_scale_ref", od, fsr);
    wr(ADDR_AUDIO_CTRL, 8'h00);
    wr(ADDR_MIN_INPUT, 8'h19);
    wr(ADDR_MAX_INPUT, 8'h80);
    wr(ADDR_MIN_DRIVE, 8'h19);
    wr(ADDR_MAX_DRIVE, 8'hc0);
    @(posedge clk);
    #2 amode = 1'b1;
    set_in(8'hff);
    wait_upd(5);
    check("drive_level", 8'hc0, drv);
    set_in(8'h60);
    wait_upd(5);
    n_tests++;
    if (drv < map_lvl('h5d) || drv > map_lvl('h60)) begin
      n_errors++;
      $display("CHECK FAILED drive_level expected %h seen %h",
               map_lvl('h60), drv);
    end
    wr(ADDR_AUDIO_CTRL, 8'h0d);
    set_in(8'h10);
    wait_upd(5);
    check("drive_level", 8'h00, drv);
    i = 0;
    @(negedge clk);
    while (upd !== 1'b1 && i < 200) begin
      @(negedge clk);
      i++;
    end
    check("window cycles", 8'(4 * PEAK_STEP_MS * TB_TICK - 1), i[7:0]);
    repeat (4) @(posedge clk);
    check("read queue", 8'h00, 8'(exp_q.size()));
    finish_test();
  end
endmodule
`default_nettype wire
